//--- rtl/mes_pkg.sv
// constants and carrier types for the motion event status readout
// Functional notes
// - event register at 0x02, bits 7..0 motion,pixel,first,overflow,reset,switch,tap,finger
// - motion pending set when displacement waits, cleared when both axes cleared
// - any event register write clears motion, overflow and both axes; data discarded
// - reset seen set by any reset, held until event register written
// - wide per-axis accumulators; overflow of either sets overflow flag
// - overflow clears after motion read and neither accumulator at full scale
// - pixel ready flag shows a valid pixel byte waits; host checks first
// - first pixel flag set on grab write or after whole array read
// - switch click flag set on click, cleared by reading 0x12
// - tap flag set on soft click, cleared by reading 0x7F
// - finger change flag set on presence change, cleared by reading 0x7A
// - 0x03 reads horizontal 8-bit two's complement displacement, a read subtracts the value it returns
// - 0x04 reads vertical 8-bit two's complement displacement, a read subtracts the value it returns
// - 0x05 reads upper 8 of 9-bit feature count, never above 167
// - read-only 8-bit silicon revision register
package mes_pkg;
  localparam logic [6:0] ADDR_REVISION = 7'h01;
  localparam logic [6:0] ADDR_EVENT    = 7'h02;
  localparam logic [6:0] ADDR_DX       = 7'h03;
  localparam logic [6:0] ADDR_DY       = 7'h04;
  localparam logic [6:0] ADDR_QUALITY  = 7'h05;
  localparam logic [6:0] ADDR_SWITCH   = 7'h12;
  localparam logic [6:0] ADDR_FINGER   = 7'h7A;
  localparam logic [6:0] ADDR_TAP      = 7'h7F;
  localparam int BIT_MOTION   = 7;
  localparam int BIT_PIXEL_BYTE_READY   = 6;
  localparam int BIT_FIRST    = 5;
  localparam int BIT_OVERFLOW = 4;
  localparam int BIT_RESET    = 3;
  localparam int BIT_SWITCH   = 2;
  localparam int BIT_TAP      = 1;
  localparam int BIT_FINGER   = 0;
  localparam int ACC_W        = 12;
  localparam logic [7:0] QUALITY_MAX   = 8'hA7;
  localparam logic [7:0] EVENT_RESET   = 8'h08;
  // arbitrary value, not tied to any real part
  localparam logic [7:0] REVISION_DEF  = 8'h00;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } mes_req_s;

  typedef struct packed {
    logic       motion_step;
    logic [7:0] dx_step;
    logic [7:0] dy_step;
    logic       pixel_valid;
    logic       pixel_wrap;
    logic       switch_click;
    logic       tap_click;
    logic       finger_present;
    logic [8:0] feature_count;
  } mes_evt_s;
endpackage

//--- rtl/mes_axis_acc.sv
// one axis displacement accumulator with saturation; a read takes out only the clipped chunk it returns
`timescale 1ns/1ps
module mes_axis_acc #(
  parameter int W = mes_pkg::ACC_W
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       add,
  input  wire logic [7:0] step,
  input  wire logic       take,
  input  wire logic       clear,
  output logic [7:0]      part,
  output logic            pending,
  output logic            full,
  output logic            ovf
);
  import mes_pkg::*;
  typedef struct packed {
    logic signed [W-1:0] acc;
  } mes_acc_s;
  localparam logic signed [W-1:0] MAXV = {1'b0, {(W-1){1'b1}}};
  localparam logic signed [W-1:0] MINV = {1'b1, {(W-1){1'b0}}};
  mes_acc_s r;
  mes_acc_s next_r;
  logic signed [W:0]   sum;
  logic signed [W-1:0] chunk;

  // chunk handed out on a read is clipped to what 8 bits carry
  always_comb begin
    if (r.acc > W'(signed'(8'sh7F))) begin
      chunk = W'(signed'(8'sh7F));
    end else if (r.acc < W'(signed'(8'sh80))) begin
      chunk = W'(signed'(8'sh80));
    end else begin
      chunk = r.acc;
    end
  end

  always_comb begin
    next_r = r;
    sum = {r.acc[W-1], r.acc};
    ovf = 1'b0;
    if (take) begin
      sum = sum - (W+1)'(chunk);
    end
    if (add) begin
      sum = sum + (W+1)'(signed'(step));
    end
    if (sum > (W+1)'(MAXV)) begin
      next_r.acc = MAXV;
      ovf = add;
    // signed compare; a concatenation here would turn it unsigned
    end else if (sum < (W+1)'(MINV)) begin
      next_r.acc = MINV;
      ovf = add;
    end else begin
      next_r.acc = sum[W-1:0];
    end
    if (clear) begin
      next_r.acc = '0;
    end
  end

  assign part    = chunk[7:0];
  assign pending = (r.acc != '0);
  assign full    = (r.acc == MAXV) || (r.acc == MINV);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

//--- rtl/mes_status.sv
// event flags, displacement readout and image quality register block
`timescale 1ns/1ps
module mes_status #(
  parameter logic [7:0] REVISION = mes_pkg::REVISION_DEF
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire mes_pkg::mes_req_s req,
  input  wire mes_pkg::mes_evt_s evt,
  input  wire logic             soft_reset,
  output logic [7:0]            rdata,
  output logic                  rvalid,
  output logic                  motion_pending,
  output logic                  reset_seen
);
  import mes_pkg::*;

  typedef struct packed {
    logic [7:0] flags;
    logic       finger_last;
    logic       motion_read;
    logic [7:0] quality;
    logic [7:0] rdata;
    logic       rvalid;
  } mes_state_s;

  mes_state_s r;
  mes_state_s next_r;

  logic       rd_dx;
  logic       rd_dy;
  logic       wr_evt;
  logic [7:0] dx_part;
  logic [7:0] dy_part;
  logic       dx_pend;
  logic       dy_pend;
  logic       dx_full;
  logic       dy_full;
  logic       dx_ovf;
  logic       dy_ovf;
  logic [7:0] q8;

  assign rd_dx  = req.rd && (req.addr == ADDR_DX);
  assign rd_dy  = req.rd && (req.addr == ADDR_DY);
  assign wr_evt = req.wr && (req.addr == ADDR_EVENT);

  mes_axis_acc #(.W(ACC_W)) u_x (
    .clk     (clk),
    .rst_n   (rst_n),
    .add     (evt.motion_step),
    .step    (evt.dx_step),
    .take    (rd_dx),
    .clear   (wr_evt),
    .part    (dx_part),
    .pending (dx_pend),
    .full    (dx_full),
    .ovf     (dx_ovf)
  );

  mes_axis_acc #(.W(ACC_W)) u_y (
    .clk     (clk),
    .rst_n   (rst_n),
    .add     (evt.motion_step),
    .step    (evt.dy_step),
    .take    (rd_dy),
    .clear   (wr_evt),
    .part    (dy_part),
    .pending (dy_pend),
    .full    (dy_full),
    .ovf     (dy_ovf)
  );

  // upper 8 of 9-bit count, clipped so the register never passes the limit
  always_comb begin
    q8 = evt.feature_count[8:1];
    if (q8 > QUALITY_MAX) begin
      q8 = QUALITY_MAX;
    end
  end

  always_comb begin
    next_r = r;
    next_r.rvalid = req.rd;
    next_r.finger_last = evt.finger_present;
    next_r.quality = q8;
    if (rd_dx || rd_dy) begin
      next_r.motion_read = 1'b1;
    end
    // clears first so that a same-cycle event still sets the flag
    if (wr_evt) begin
      next_r.flags[BIT_OVERFLOW] = 1'b0;
      next_r.flags[BIT_RESET] = 1'b0;
      next_r.motion_read = 1'b0;
    end
    if (next_r.motion_read && !dx_full && !dy_full) begin
      next_r.flags[BIT_OVERFLOW] = 1'b0;
      next_r.motion_read = 1'b0;
    end
    if (req.rd && req.addr == ADDR_SWITCH) begin
      next_r.flags[BIT_SWITCH] = 1'b0;
    end
    if (req.rd && req.addr == ADDR_TAP) begin
      next_r.flags[BIT_TAP] = 1'b0;
    end
    if (req.rd && req.addr == ADDR_FINGER) begin
      next_r.flags[BIT_FINGER] = 1'b0;
    end
    // motion pending follows held data; a write also empties both axes
    next_r.flags[BIT_MOTION] = !wr_evt &&
      (dx_pend || dy_pend || evt.motion_step);
    next_r.flags[BIT_PIXEL_BYTE_READY] = evt.pixel_valid;
    next_r.flags[BIT_FIRST]  = evt.pixel_wrap;
    if (dx_ovf || dy_ovf) begin
      next_r.flags[BIT_OVERFLOW] = 1'b1;
    end
    if (soft_reset) begin
      next_r.flags[BIT_RESET] = 1'b1;
    end
    if (evt.switch_click) begin
      next_r.flags[BIT_SWITCH] = 1'b1;
    end
    if (evt.tap_click) begin
      next_r.flags[BIT_TAP] = 1'b1;
    end
    if (evt.finger_present != r.finger_last) begin
      next_r.flags[BIT_FINGER] = 1'b1;
    end
    next_r.rdata = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        ADDR_REVISION: next_r.rdata = REVISION;
        ADDR_EVENT:    next_r.rdata = r.flags;
        ADDR_DX:       next_r.rdata = dx_part;
        ADDR_DY:       next_r.rdata = dy_part;
        ADDR_QUALITY:  next_r.rdata = r.quality;
        default:       next_r.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.flags <= EVENT_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign rdata          = r.rdata;
  assign rvalid         = r.rvalid;
  assign motion_pending = r.flags[BIT_MOTION];
  assign reset_seen     = r.flags[BIT_RESET];
endmodule

//--- bench/mes_status_monitor.sv
// port assertions for the status readout block
`timescale 1ns/1ps
module mes_status_monitor
  import mes_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire mes_req_s   req,
  input wire mes_evt_s   evt,
  input wire logic       soft_reset,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  input wire logic       motion_pending,
  input wire logic       reset_seen
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire ev_wr = req.wr && req.addr == ADDR_EVENT;
  wire ev_rd = req.rd && req.addr == ADDR_EVENT;
  property p_ans; req.rd |=> rvalid; endproperty
  property p_idle; !req.rd |=> !rvalid; endproperty
  // a set in the same cycle wins, so only clean writes are judged
  property p_rclr; ev_wr && !soft_reset |=> !reset_seen; endproperty
  property p_mclr;
    ev_wr && !evt.motion_step && !$past(evt.motion_step) |=> !motion_pending;
  endproperty
  property p_rhold; reset_seen && !ev_wr |=> reset_seen; endproperty
  property p_soft; soft_reset |=> reset_seen; endproperty
  property p_qual;
    req.rd && req.addr == ADDR_QUALITY |=> rdata <= QUALITY_MAX;
  endproperty
  property p_evt; ev_rd |=> rdata[BIT_RESET] == $past(reset_seen); endproperty
  property p_mset; evt.motion_step && !ev_wr |=> motion_pending; endproperty
  a_ans: assert property (p_ans) else $error("no read answer");
  a_idle: assert property (p_idle) else $error("stray rvalid");
  a_rclr: assert property (p_rclr) else $error("reset flag kept");
  a_mclr: assert property (p_mclr) else $error("motion kept");
  a_rhold: assert property (p_rhold) else $error("reset flag lost");
  a_soft: assert property (p_soft) else $error("soft reset unseen");
  a_qual: assert property (p_qual) else $error("quality too big");
  a_evt: assert property (p_evt) else $error("event bit3 wrong");
  a_mset: assert property (p_mset) else $error("motion not raised");
  c_wr: cover property (ev_wr);
  c_mot: cover property (motion_pending ##1 !motion_pending);
  c_soft: cover property (soft_reset);
endmodule
bind mes_status mes_status_monitor u_mon (.clk(clk), .rst_n(rst_n),
  .req(req), .evt(evt), .soft_reset(soft_reset), .rdata(rdata),
  .rvalid(rvalid), .motion_pending(motion_pending),
  .reset_seen(reset_seen));

//--- bench/mes_host.sv
// host model issuing register reads and writes
`timescale 1ns/1ps
module mes_host
  import mes_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid,
  output mes_req_s        req
);
  initial req = '0;
  // released address shows its inverse, never the stale value
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk) #1;
    req.rd = 1'b1;
    req.addr = a;
    @(posedge clk) #1;
    req.rd = 1'b0;
    req.addr = ~a;
    d = rvalid ? rdata : 8'hXX;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge clk) #1;
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = v;
    @(posedge clk) #1;
    req.wr = 1'b0;
    req.addr = ~a;
    req.wdata = ~v;
  endtask
endmodule

//--- bench/tb_mes_status.sv
// testbench for the status readout block
`timescale 1ns/1ps
module tb_mes_status;
  import mes_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       soft_reset = 1'b0;
  mes_evt_s   evt = '0;
  mes_req_s   req;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [7:0] dx_rd;
  logic [7:0] dy_rd;
  logic       rvalid;
  logic       motion_pending;
  logic       reset_seen;
  int         n_fail = 0;
  int         n_tests = 0;
  int         i;
  always #10 clk = ~clk;
  mes_status dut (.clk(clk), .rst_n(rst_n), .req(req), .evt(evt),
    .soft_reset(soft_reset), .rdata(rdata), .rvalid(rvalid),
    .motion_pending(motion_pending), .reset_seen(reset_seen));
  mes_host host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));
  task automatic chk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] g;
    host.rd(a, g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t addr %h got %h exp %h", $time, a, g, e);
    end
  endtask
  task automatic results;
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic step(input logic [7:0] x, input logic [7:0] y, input int n);
    repeat (n) begin
      @(posedge clk) #1;
      evt.motion_step = 1'b1;
      evt.dx_step = x;
      evt.dy_step = y;
    end
    @(posedge clk) #1;
    evt.motion_step = 1'b0;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    chk(ADDR_EVENT, EVENT_RESET);
    chk(ADDR_REVISION, REVISION_DEF);
    host.wr(ADDR_REVISION, 8'hFF);
    chk(ADDR_REVISION, REVISION_DEF);
    chk(7'h06, 8'h00);
    evt.feature_count = 9'h1FF;
    step(8'h00, 8'h00, 0);
    chk(ADDR_QUALITY, QUALITY_MAX);
    evt.feature_count = 9'h0A4;
    soft_reset = 1'b1;
    @(posedge clk) #1 soft_reset = 1'b0;
    chk(ADDR_QUALITY, 8'h52);
    chk(ADDR_EVENT, EVENT_RESET);
    host.wr(ADDR_EVENT, 8'hFF);
    chk(ADDR_EVENT, 8'h00);
    step(8'h05, 8'hFD, 1);
    chk(ADDR_EVENT, 8'h80);
    chk(ADDR_DX, 8'h05);
    chk(ADDR_DY, 8'hFD);
    chk(ADDR_EVENT, 8'h00);
    // forty steps saturate both axes in opposite directions
    step(8'h7F, 8'h81, 40);
    chk(ADDR_EVENT, 8'h90);
    host.wr(ADDR_EVENT, 8'h00);
    chk(ADDR_EVENT, 8'h00);
    chk(ADDR_DX, 8'h00);
    step(8'h7F, 8'h81, 40);
    i = 0;
    do begin
      host.rd(ADDR_EVENT, d);
      host.rd(ADDR_DX, dx_rd);
      host.rd(ADDR_DY, dy_rd);
      i++;
    end while (d[BIT_MOTION] !== 1'b0 && i < 32);
    n_tests++;
    if (d[BIT_MOTION] !== 1'b0) begin
      n_fail++;
      $display("[FAIL] %0t motion pending never drained", $time);
      results();
    end
    chk(ADDR_EVENT, 8'h00);
    evt.switch_click = 1'b1;
    evt.tap_click = 1'b1;
    evt.finger_present = 1'b1;
    evt.pixel_valid = 1'b1;
    evt.pixel_wrap = 1'b1;
    repeat (2) @(posedge clk);
    #1 evt.switch_click = 1'b0;
    evt.tap_click = 1'b0;
    chk(ADDR_EVENT, 8'h67);
    host.rd(ADDR_SWITCH, d);
    chk(ADDR_EVENT, 8'h63);
    host.rd(ADDR_TAP, d);
    chk(ADDR_EVENT, 8'h61);
    host.rd(ADDR_FINGER, d);
    chk(ADDR_EVENT, 8'h60);
    evt.pixel_valid = 1'b0;
    chk(ADDR_EVENT, 8'h20);
    evt.pixel_wrap = 1'b0;
    chk(ADDR_EVENT, 8'h00);
    results();
  end
endmodule
